// ===== core/asr_char_if.sv
// Purpose: Carries one received character from the framer to the FIFO
// Assumes: Single clock domain
// Notes: push is a one-cycle strobe
`timescale 1ns/1ns
interface asr_char_if;
    logic push;
    logic [8:0] data;
    logic frameErr;

    modport framer (output push, output data, output frameErr);
    modport fifo (input push, input data, input frameErr);
endinterface

// ===== core/asr_pkg.sv
// Purpose: Shared constants and types for the async serial receiver
// Assumes: 16x oversampling tick derived from a divider on clk_sys
// Notes: Counts are in oversampling ticks unless named otherwise
package asr_pkg;
    // ----------------------------------------
    // Oversampling and framing
    // ----------------------------------------
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
    localparam logic [3:0] FULL_BIT_TICKS = 4'hf;
    localparam logic [3:0] VOTE_FIRST_TICK = 4'h6;
    localparam int DATA_BITS_MAX = 9;
    localparam int FIFO_DEPTH = 2;
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0001;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } asr_state_e;
endpackage

// ===== core/asr_receiver.sv
// Purpose: Asynchronous serial receiver with 16x oversampling and 2-deep FIFO
// Assumes: rxLine synchronous to clk_sys; baudDiv sets clk_sys cycles per tick
// Notes: Outputs registered; pending flag follows FIFO occupancy
//
// Functional notes
// - A character starts only on a falling edge of the idle-high line.
// - Half a bit after the edge the line must still be low.
// - A high line at mid start bit drops the attempt silently.
// - Each following bit center is one bit apart and sampled by majority vote into the shift register.
// - One bit after the last data bit the stop position is sampled.
// - A low stop sample sets the framing error for that character, a high one clears it.
// - Right after the stop sample the character enters the FIFO if a slot is free, and pending is set.
// - Reading the data port returns and removes the oldest character.
// - Pending is high when enabled and the FIFO holds an unread character.
// - Pending cannot be written by software; it follows occupancy only.
// - The interrupt request needs pending and all three enables.
// - Pending ignores every interrupt enable.
// - Recovery runs at sixteen ticks per bit; eight or nine data bits per character.
// - The FIFO holds two characters while a third shifts in, reached only via the read port.
`timescale 1ns/1ns
module asr_receiver #(
    parameter int FIFO_DEPTH = asr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial line
    input wire logic rxLine,
    // Control
    input wire logic continuousReceiveEnable,
    input wire logic serialPortEnable,
    input wire logic clockedModeSelect,
    input wire logic nineBitMode,
    input wire logic [15:0] baudDiv,
    input wire logic rxIrqEnable,
    input wire logic peripheralIrqEnable,
    input wire logic globalIrqEnable,
    // Data read port
    input wire logic rxDataRead,
    output logic [8:0] rxDataReadPort,
    output logic rxFrameError,
    output logic rxOverrun,
    // Status and interrupt
    output logic rxCharPendingFlag,
    output logic rxIrq,
    output logic rxBusy
);
    typedef struct packed {
        asr_pkg::asr_state_e state;
        logic lineLast;
        logic [15:0] divCnt;
        logic [3:0] tickCnt;
        logic [3:0] bitCnt;
        logic [1:0] votes;
        logic [8:0] receiveShiftRegister;
        logic push;
        logic [8:0] pushData;
        logic pushErr;
        logic [8:0] outData;
        logic outErr;
        logic ovr;
        logic pending;
        logic irq;
        logic busy;
    } asr_s;

    asr_s s_q, s_d;

    asr_char_if chr ();

    logic enabled;
    logic fifoNotEmpty;
    logic fifoOvf;
    logic [8:0] headData;
    logic headErr;
    logic popNow;

    assign enabled = continuousReceiveEnable && serialPortEnable && !clockedModeSelect;
    assign popNow = rxDataRead && fifoNotEmpty;

    function automatic logic majority(input logic [1:0] cnt, input logic last);
        majority = ((2'(cnt) + 2'(last)) >= 2'h2);
    endfunction

    assign chr.push = s_q.push;
    assign chr.data = s_q.pushData;
    assign chr.frameErr = s_q.pushErr;

    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    // Two entries plus shifter
    asr_rx_fifo #(
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inChar(chr),
        .pop(rxDataRead),
        .flush(!enabled),
        .headData(headData),
        .headFrameErr(headErr),
        .notEmpty(fifoNotEmpty),
        .overflow(fifoOvf)
    );

    // ----------------------------------------
    // Framer
    // ----------------------------------------
    always_comb begin
        logic tick;
        logic [3:0] lastBit;
        logic bitVal;
        tick = 1'b0;
        lastBit = nineBitMode ? 4'h8 : 4'h7;
        bitVal = majority(s_q.votes, rxLine);
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.lineLast = rxLine;
        if (s_q.divCnt >= baudDiv - 16'h0001 || baudDiv == 16'h0000) begin
            s_d.divCnt = '0;
            tick = 1'b1;
        end else begin
            s_d.divCnt = s_q.divCnt + 16'h0001;
        end
        if (tick) begin
            s_d.tickCnt = s_q.tickCnt + 4'h1;
            if (s_q.tickCnt == asr_pkg::VOTE_FIRST_TICK) begin
                s_d.votes = 2'(rxLine);
            end else if (s_q.tickCnt == asr_pkg::HALF_BIT_TICKS) begin
                s_d.votes = s_q.votes + 2'(rxLine);
            end
        end
        case (s_q.state)
            asr_pkg::ST_IDLE: begin
                if (s_q.lineLast && !rxLine) begin
                    s_d.state = asr_pkg::ST_START;
                    s_d.tickCnt = '0;
                    s_d.divCnt = '0;
                    s_d.votes = '0;
                end
            end
            asr_pkg::ST_START: begin
                // Third vote on the center tick, as for data bits
                if (tick && s_q.tickCnt == asr_pkg::HALF_BIT_TICKS + 4'h1) begin
                    if (bitVal) begin
                        s_d.state = asr_pkg::ST_IDLE;
                    end else begin
                        s_d.state = asr_pkg::ST_DATA;
                        s_d.bitCnt = '0;
                    end
                end
            end
            asr_pkg::ST_DATA: begin
                if (tick && s_q.tickCnt == asr_pkg::HALF_BIT_TICKS + 4'h1) begin
                    s_d.receiveShiftRegister = {bitVal, s_q.receiveShiftRegister[8:1]};
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                    if (s_q.bitCnt == lastBit) begin
                        s_d.state = asr_pkg::ST_STOP;
                    end
                end
            end
            asr_pkg::ST_STOP: begin
                if (tick && s_q.tickCnt == asr_pkg::HALF_BIT_TICKS + 4'h1) begin
                    s_d.state = asr_pkg::ST_IDLE;
                    s_d.push = 1'b1;
                    s_d.pushData = nineBitMode ? s_q.receiveShiftRegister
                        : {1'b0, s_q.receiveShiftRegister[8:1]};
                    s_d.pushErr = !bitVal;
                end
            end
            default: begin
                s_d.state = asr_pkg::ST_IDLE;
            end
        endcase
        if (!enabled) begin
            s_d.state = asr_pkg::ST_IDLE;
            s_d.push = 1'b0;
        end
        s_d.outData = headData;
        s_d.outErr = headErr;
        s_d.ovr = s_q.ovr | fifoOvf;
        if (popNow && !fifoOvf) begin
            s_d.ovr = 1'b0;
        end
        s_d.pending = enabled && fifoNotEmpty;
        s_d.irq = s_d.pending && rxIrqEnable && peripheralIrqEnable && globalIrqEnable;
        // Registered copy of the frame-in-progress state
        s_d.busy = (s_d.state != asr_pkg::ST_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.lineLast <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rxDataReadPort = s_q.outData;
    assign rxFrameError = s_q.outErr;
    assign rxOverrun = s_q.ovr;
    assign rxCharPendingFlag = s_q.pending;
    assign rxIrq = s_q.irq;
    assign rxBusy = s_q.busy;
endmodule

// ===== core/asr_rx_fifo.sv
// Purpose: Two-entry receive FIFO holding character and framing error
// Assumes: Overflow drops the newest character
// Notes: Storage only reachable through the pop port
`timescale 1ns/1ns
module asr_rx_fifo #(
    parameter int DEPTH = asr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Write side
    asr_char_if.fifo inChar,
    // Read side
    input wire logic pop,
    input wire logic flush,
    output logic [8:0] headData,
    output logic headFrameErr,
    output logic notEmpty,
    output logic overflow
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][9:0] mem;
        logic [PW-1:0] rdPtr;
        logic [PW-1:0] wrPtr;
        logic [PW:0] count;
        logic ovf;
    } asrf_s;

    asrf_s s_q, s_d;

    function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
        ptrInc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    always_comb begin
        logic doPush;
        logic doPop;
        doPush = inChar.push && (s_q.count != (PW+1)'(DEPTH));
        doPop = pop && (s_q.count != '0);
        s_d = s_q;
        s_d.ovf = inChar.push && !doPush;
        if (doPush) begin
            s_d.mem[s_q.wrPtr] = {inChar.frameErr, inChar.data};
            s_d.wrPtr = ptrInc(s_q.wrPtr);
        end
        if (doPop) begin
            s_d.rdPtr = ptrInc(s_q.rdPtr);
        end
        s_d.count = (PW+1)'(s_q.count + doPush - doPop);
        if (flush) begin
            s_d.rdPtr = '0;
            s_d.wrPtr = '0;
            s_d.count = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign headData = s_q.mem[s_q.rdPtr][8:0];
    assign headFrameErr = s_q.mem[s_q.rdPtr][9];
    assign notEmpty = (s_q.count != '0);
    assign overflow = s_q.ovf;
endmodule

// ===== verification/asr_receiver_properties.sv
// Purpose: Port-level checks for asr_receiver
// Assumes: Frame length check only when baudDiv is one
// Notes: Attached by the bind at the foot
`timescale 1ns/1ns
module asr_receiver_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Watched ports
    input wire logic rxLine,
    input wire logic continuousReceiveEnable,
    input wire logic serialPortEnable,
    input wire logic clockedModeSelect,
    input wire logic [15:0] baudDiv,
    input wire logic rxIrqEnable,
    input wire logic peripheralIrqEnable,
    input wire logic globalIrqEnable,
    input wire logic rxDataRead,
    input wire logic rxOverrun,
    input wire logic rxCharPendingFlag,
    input wire logic rxIrq,
    input wire logic rxBusy
);
    logic [7:0] busyCnt_q;
    logic rxOn;
    assign rxOn = continuousReceiveEnable && serialPortEnable && !clockedModeSelect;
    // Saturates well past the longest frame at a baudDiv of one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt_q <= 8'h00;
        end else begin
            busyCnt_q <= !rxBusy ? 8'h00 : (busyCnt_q == 8'hff ? busyCnt_q : busyCnt_q + 8'h01);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_pendEn;
        (rxCharPendingFlag && rxIrqEnable && peripheralIrqEnable && globalIrqEnable)[*2];
    endsequence
    sequence s_offLong;
        (!rxOn)[*4];
    endsequence
    property p_startEdge; $rose(rxBusy) |-> !$past(rxLine); endproperty
    a_startEdge: assert property (p_startEdge) else $error("frame began without a low line");
    property p_startHold; $rose(rxBusy) |-> rxBusy[*6]; endproperty
    a_startHold: assert property (p_startHold) else $error("start dropped before mid bit");
    property p_frameLen;
        $fell(rxBusy) && baudDiv == 16'h0001 && busyCnt_q > 8'h14 |-> busyCnt_q inside {[8'h8c:8'hbe]};
    endproperty
    a_frameLen: assert property (p_frameLen) else $error("frame length off");
    property p_irqOff; !(rxIrqEnable && peripheralIrqEnable && globalIrqEnable) |=> !rxIrq; endproperty
    a_irqOff: assert property (p_irqOff) else $error("irq with an enable clear");
    property p_irqOn; s_pendEn |-> rxIrq; endproperty
    a_irqOn: assert property (p_irqOn) else $error("irq missing");
    property p_offNoPend; s_offLong |-> !rxCharPendingFlag; endproperty
    a_offNoPend: assert property (p_offNoPend) else $error("pending while disabled");
    property p_pendFall;
        $fell(rxCharPendingFlag) |-> $past(rxDataRead, 2) || !rxOn || !$past(rxOn) || !$past(rxOn, 2);
    endproperty
    a_pendFall: assert property (p_pendFall) else $error("pending fell without a read");
    property p_overrun; $rose(rxOverrun) |-> rxCharPendingFlag; endproperty
    a_overrun: assert property (p_overrun) else $error("overrun with room left");
    property p_pendRise; $rose(rxCharPendingFlag) |-> $past(rxOn) && $past(rxOn, 2); endproperty
    a_pendRise: assert property (p_pendRise) else $error("pending rose while disabled");
endmodule
bind asr_receiver asr_receiver_properties u_props (.clk_sys, .rst_n, .rxLine, .continuousReceiveEnable,
    .serialPortEnable, .clockedModeSelect, .baudDiv, .rxIrqEnable, .peripheralIrqEnable,
    .globalIrqEnable, .rxDataRead, .rxOverrun, .rxCharPendingFlag, .rxIrq, .rxBusy);

// ===== verification/asr_tx_model.sv
// Purpose: Remote transmitter driving the receive line
// Assumes: Called at a falling clock edge
// Notes: Line rests high between characters
`timescale 1ns/1ns
module asr_tx_model #(
    parameter int BIT_CYCLES = 16
) (
    // Clock and line
    input wire logic clk_sys,
    output logic line
);
    // Bench may change the bit length between characters
    int bitCycles = BIT_CYCLES;
    initial line = 1'b1;
    task automatic drive(input logic v, input int n);
        line = v;
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic send(input logic [8:0] d, input logic nine, input logic stopVal);
        drive(1'b0, bitCycles);
        for (int i = 0; i < (nine ? 9 : 8); i++) drive(d[i], bitCycles);
        drive(stopVal, bitCycles);
        drive(1'b1, 4);
    endtask
endmodule

// ===== verification/tb_asr_receiver.sv
// Purpose: Self-checking bench for asr_receiver
// Assumes: baudDiv of one, sixteen clocks per bit, except the slow-rate case
// Notes: Rows first, then hand-written cases
`timescale 1ns/1ns
module tb_asr_receiver;
    typedef struct {logic [8:0] d; logic nine; logic stopOk; logic [8:0] expD; logic expFe;} asr_row_s;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic rxLine, continuousReceiveEnable, serialPortEnable, clockedModeSelect, nineBitMode;
    logic rxIrqEnable, peripheralIrqEnable, globalIrqEnable, rxDataRead;
    logic [15:0] baudDiv;
    logic [8:0] rxDataReadPort;
    logic rxFrameError, rxOverrun, rxCharPendingFlag, rxIrq, rxBusy;
    int n_mismatch = 0;
    int n_compared = 0;
    asr_row_s rows[4] = '{'{9'h055, 1'b0, 1'b1, 9'h055, 1'b0}, '{9'h1a3, 1'b0, 1'b0, 9'h0a3, 1'b1},
                          '{9'h1c5, 1'b1, 1'b1, 9'h1c5, 1'b0}, '{9'h100, 1'b1, 1'b0, 9'h100, 1'b1}};
    always #2 clk_sys = ~clk_sys;
    asr_tx_model #(.BIT_CYCLES(16)) tx (.clk_sys, .line(rxLine));
    asr_receiver dut (.clk_sys, .rst_n, .rxLine, .continuousReceiveEnable, .serialPortEnable,
        .clockedModeSelect, .nineBitMode, .baudDiv, .rxIrqEnable, .peripheralIrqEnable, .globalIrqEnable,
        .rxDataRead, .rxDataReadPort, .rxFrameError, .rxOverrun, .rxCharPendingFlag, .rxIrq, .rxBusy);
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic rx(input logic [8:0] d, input logic nine, input logic stopOk);
        nineBitMode = nine;
        tx.send(d, nine, stopOk);
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic pop();
        rxDataRead = 1'b1;
        @(negedge clk_sys);
        rxDataRead = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {clockedModeSelect, nineBitMode, rxDataRead} = 3'h0;
        {continuousReceiveEnable, serialPortEnable, rxIrqEnable, peripheralIrqEnable, globalIrqEnable} = 5'h1f;
        baudDiv = 16'h0001;
        repeat (6) @(negedge clk_sys);
        check(rxCharPendingFlag, 9'h000);
        check(rxDataReadPort, 9'h000);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        foreach (rows[i]) begin
            rx(rows[i].d, rows[i].nine, rows[i].stopOk);
            check(rxCharPendingFlag, 9'h001);
            check(rxDataReadPort, rows[i].expD);
            check(rxFrameError, rows[i].expFe);
            check(rxIrq, 9'h001);
            pop();
            check(rxCharPendingFlag, 9'h000);
            $display("row %0d done", i);
        end
        tx.drive(1'b0, 4);
        check(rxBusy, 9'h001);
        tx.drive(1'b1, 200);
        check(rxBusy, 9'h000);
        check(rxCharPendingFlag, 9'h000);
        check(rxFrameError, 9'h000);
        $display("false start done");
        globalIrqEnable = 1'b0;
        rx(9'h03c, 1'b0, 1'b1);
        check(rxCharPendingFlag, 9'h001);
        check(rxIrq, 9'h000);
        check(rxDataReadPort, 9'h03c);
        pop();
        globalIrqEnable = 1'b1;
        $display("masked irq done");
        rx(9'h011, 1'b0, 1'b0);
        rx(9'h022, 1'b0, 1'b1);
        rx(9'h033, 1'b0, 1'b1);
        check(rxOverrun, 9'h001);
        check(rxDataReadPort, 9'h011);
        check(rxFrameError, 9'h001);
        pop();
        check(rxOverrun, 9'h000);
        check(rxDataReadPort, 9'h022);
        check(rxFrameError, 9'h000);
        pop();
        check(rxCharPendingFlag, 9'h000);
        $display("fifo depth done");
        rx(9'h077, 1'b0, 1'b1);
        continuousReceiveEnable = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(rxCharPendingFlag, 9'h000);
        check(rxIrq, 9'h000);
        continuousReceiveEnable = 1'b1;
        clockedModeSelect = 1'b1;
        rx(9'h044, 1'b0, 1'b1);
        check(rxCharPendingFlag, 9'h000);
        clockedModeSelect = 1'b0;
        serialPortEnable = 1'b0;
        rx(9'h045, 1'b0, 1'b1);
        check(rxCharPendingFlag, 9'h000);
        serialPortEnable = 1'b1;
        $display("disable done");
        // One-cycle high spike on the second vote tick of bit 0, one tick before the center
        tx.drive(1'b0, 24);
        tx.drive(1'b1, 1);
        tx.drive(1'b0, 119);
        tx.drive(1'b1, 24);
        check(rxCharPendingFlag, 9'h001);
        check(rxDataReadPort, 9'h000);
        check(rxFrameError, 9'h000);
        pop();
        $display("glitch vote done");
        baudDiv = 16'h0002;
        tx.bitCycles = 32;
        rx(9'h0b6, 1'b0, 1'b1);
        check(rxCharPendingFlag, 9'h001);
        check(rxDataReadPort, 9'h0b6);
        pop();
        baudDiv = 16'h0001;
        tx.bitCycles = 16;
        $display("slow rate done");
        rx(9'h0e1, 1'b0, 1'b1);
        rst_n = 1'b0;
        @(negedge clk_sys);
        check(rxCharPendingFlag, 9'h000);
        check(rxDataReadPort, 9'h000);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        rx(9'h05a, 1'b0, 1'b1);
        check(rxCharPendingFlag, 9'h001);
        check(rxDataReadPort, 9'h05a);
        $display("mid reset done");
        end_of_test();
    end
endmodule
